// ===== rtl/ddcd_pkg.sv
// Constants and types for the dual converter command decoder
// Function
// RL1: Command 000001 loads both staging and outputs
// RL2: Command 000010 loads first channel staging, output
// RL3: Command 000011 loads second channel staging, output
// RL4: Command 000100 loads both staging, outputs kept
// RL5: Command 000101 loads first channel staging only
// RL6: Command 000110 loads second channel staging only
// RL7: Command 000111 copies both staging to outputs
// RL8: Command 001001 copies first staging to output
// RL9: Command 001010 copies second staging to output
// RL10: 001011 internal, 001100 external reference; external default
// RL11: 001101/001110/001111 shut down both, first, second
// RL12: 101101/101110/101111 power up both, first, second
// RL13: 010000-010101 set first channel range; lowest default
// RL14: 110000-110101 set second channel range; lowest default
// RL15: No-op and unassigned codes change nothing
// RL16: Shutdown, power-up, range keep stored codes
// RL17: Frame: six command, eight data, two sub-bits
// RL18: Serial mode executes when chip select rises
// RL19: Two-wire mode executes at 26th clock; abort discards
// RL20: Commands still execute while outputs shut down
package ddcd_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 10;
   localparam int DATA_MSB = 9;
   localparam int DATA_LSB = 2;
   localparam int TW_UPDATE_PULSE = 26;
   typedef logic [5:0] ddcd_cmd_t;
   typedef logic [2:0] ddcd_range_t;
   localparam ddcd_cmd_t CMD_NOP = 6'h00;
   localparam ddcd_cmd_t CMD_LOAD_BOTH = 6'h01;
   localparam ddcd_cmd_t CMD_LOAD_A = 6'h02;
   localparam ddcd_cmd_t CMD_LOAD_B = 6'h03;
   localparam ddcd_cmd_t CMD_STAGE_BOTH = 6'h04;
   localparam ddcd_cmd_t CMD_STAGE_A = 6'h05;
   localparam ddcd_cmd_t CMD_STAGE_B = 6'h06;
   localparam ddcd_cmd_t CMD_UPD_BOTH = 6'h07;
   localparam ddcd_cmd_t CMD_UPD_A = 6'h09;
   localparam ddcd_cmd_t CMD_UPD_B = 6'h0A;
   localparam ddcd_cmd_t CMD_REF_INT = 6'h0B;
   localparam ddcd_cmd_t CMD_REF_EXT = 6'h0C;
   localparam ddcd_cmd_t CMD_SHDN_BOTH = 6'h0D;
   localparam ddcd_cmd_t CMD_SHDN_A = 6'h0E;
   localparam ddcd_cmd_t CMD_SHDN_B = 6'h0F;
   localparam ddcd_cmd_t CMD_PWR_BOTH = 6'h2D;
   localparam ddcd_cmd_t CMD_PWR_A = 6'h2E;
   localparam ddcd_cmd_t CMD_PWR_B = 6'h2F;
   localparam logic [2:0] CMD_RANGE_A_HI = 3'h2; // Upper bits 010
   localparam logic [2:0] CMD_RANGE_B_HI = 3'h6; // Upper bits 110
   localparam ddcd_range_t RANGE_MAX = 3'h5;     // 15-30 mA
   localparam ddcd_range_t RANGE_RST = 3'h0;     // 1-2 mA
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic REF_EXT_RST = 1'b1;
   localparam logic SHDN_RST = 1'b0;
endpackage

// ===== rtl/ddcd_sync3.sv
// Three-stage input synchroniser for pin-level signals
`timescale 1ns/100ps
`default_nettype none
module ddcd_sync3 (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Pin and filtered level
   input  wire logic pin_in,
   input  wire logic rst_val,
   output logic      level_out
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic       lvl_reg;
   logic       lvl_next;

   // Shift; the level moves only when stages two and three agree
   always_comb begin
      sh_next = {sh_reg[1:0], pin_in};
      lvl_next = lvl_reg;
      if (sh_reg[1] == sh_reg[2]) begin
         lvl_next = sh_reg[2];
      end
      if (!rst_b) begin
         sh_next = {3{rst_val}};
         lvl_next = rst_val;
      end
   end

   always_ff @(posedge clk) begin
      sh_reg <= sh_next;
      lvl_reg <= lvl_next;
   end

   assign level_out = lvl_reg;
endmodule
`default_nettype wire

// ===== rtl/ddcd_top.sv
// Command decoder top: frame capture and command execution
`timescale 1ns/100ps
`default_nettype none
module ddcd_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // Interface mode select: 1 serial, 0 two-wire
   input  wire logic                 serial_mode,
   // Serial pins
   input  wire logic                 cs_b_pin,
   input  wire logic                 sclk_pin,
   input  wire logic                 din_pin,
   // Two-wire frame from the address front end
   input  wire logic                 tw_bit_valid,
   input  wire logic                 tw_bit,
   input  wire logic                 tw_start,
   input  wire logic [4:0]           tw_pulse_cnt,
   // Channel outputs
   output logic [7:0]                stage_a,
   output logic [7:0]                stage_b,
   output logic [7:0]                code_a,
   output logic [7:0]                code_b,
   output logic                      ref_external,
   output logic                      shdn_a,
   output logic                      shdn_b,
   output ddcd_pkg::ddcd_range_t     range_a,
   output ddcd_pkg::ddcd_range_t     range_b,
   output logic                      cmd_strobe,
   output logic                      sub_bit_err
);
   import ddcd_pkg::*;

   logic cs_b_s;
   logic sclk_s;
   logic din_s;

   // Pins come from the host's domain
   ddcd_sync3 u_sync_cs (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (cs_b_pin),
      .rst_val   (1'b1),
      .level_out (cs_b_s)
   );
   ddcd_sync3 u_sync_sclk (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (sclk_pin),
      .rst_val   (1'b0),
      .level_out (sclk_s)
   );
   ddcd_sync3 u_sync_din (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    (din_pin),
      .rst_val   (1'b0),
      .level_out (din_s)
   );

   // Capture state
   logic [15:0] shift_reg, shift_next;
   logic [4:0]  cnt_reg, cnt_next;
   logic        sclk_d_reg, sclk_d_next;
   logic        cs_d_reg, cs_d_next;
   logic        exec;
   logic [15:0] frame;

   // Frame capture: serial shifts on rising clock, two-wire on bit strobes
   always_comb begin
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      sclk_d_next = sclk_s;
      cs_d_next = cs_b_s;
      exec = 1'b0;
      frame = shift_reg;
      if (serial_mode) begin
         if (!cs_b_s && sclk_s && !sclk_d_reg) begin
            // RL17 command MSB first
            shift_next = {shift_reg[14:0], din_s};
            if (cnt_reg != 5'(FRAME_BITS)) begin
               cnt_next = cnt_reg + 5'h01;
            end
         end
         // RL18 execute on rising chip select
         if (cs_b_s && !cs_d_reg) begin
            exec = (cnt_reg == 5'(FRAME_BITS));
            cnt_next = 5'h00;
         end
      end else begin
         if (tw_start) begin
            // RL19 a restart drops a partial write
            cnt_next = 5'h00;
         end else if (tw_bit_valid) begin
            shift_next = {shift_reg[14:0], tw_bit};
            frame = {shift_reg[14:0], tw_bit};
            // RL19 update on the 26th pulse only
            exec = (tw_pulse_cnt == 5'(TW_UPDATE_PULSE));
         end
      end
      if (!rst_b) begin
         shift_next = 16'h0000;
         cnt_next = 5'h00;
         sclk_d_next = 1'b0;
         cs_d_next = 1'b1;
         exec = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      sclk_d_reg <= sclk_d_next;
      cs_d_reg <= cs_d_next;
   end

   // Device state
   logic [7:0]  sa_reg, sa_next, sb_reg, sb_next;
   logic [7:0]  ca_reg, ca_next, cb_reg, cb_next;
   logic        ref_reg, ref_next;
   logic        sda_reg, sda_next, sdb_reg, sdb_next;
   ddcd_range_t ra_reg, ra_next, rb_reg, rb_next;
   logic        stb_reg, stb_next, err_reg, err_next;
   ddcd_cmd_t   cmd;
   logic [7:0]  data;

   assign cmd = frame[CMD_MSB:CMD_LSB];
   assign data = frame[DATA_MSB:DATA_LSB];

   // Command execution; shutdown never gates it, so updates land while off
   always_comb begin
      sa_next = sa_reg;
      sb_next = sb_reg;
      ca_next = ca_reg;
      cb_next = cb_reg;
      ref_next = ref_reg;
      sda_next = sda_reg;
      sdb_next = sdb_reg;
      ra_next = ra_reg;
      rb_next = rb_reg;
      stb_next = 1'b0;
      err_next = err_reg;
      // RL20 executes regardless of shutdown
      if (exec) begin
         stb_next = 1'b1;
         // RL17 sub-bits expected zero
         err_next = (frame[1:0] != 2'h0);
         // RL15 unassigned codes fall through unchanged
         case (cmd)
            // RL1 load all four
            CMD_LOAD_BOTH: begin
               sa_next = data;
               sb_next = data;
               ca_next = data;
               cb_next = data;
            end
            // RL2 first channel load
            CMD_LOAD_A: begin
               sa_next = data;
               ca_next = data;
            end
            // RL3 second channel load
            CMD_LOAD_B: begin
               sb_next = data;
               cb_next = data;
            end
            // RL4 both staging only
            CMD_STAGE_BOTH: begin
               sa_next = data;
               sb_next = data;
            end
            // RL5 first staging only
            CMD_STAGE_A: sa_next = data;
            // RL6 second staging only
            CMD_STAGE_B: sb_next = data;
            // RL7 simultaneous update
            CMD_UPD_BOTH: begin
               ca_next = sa_reg;
               cb_next = sb_reg;
            end
            // RL8 first update
            CMD_UPD_A: ca_next = sa_reg;
            // RL9 second update
            CMD_UPD_B: cb_next = sb_reg;
            // RL10 reference select
            CMD_REF_INT: ref_next = 1'b0;
            CMD_REF_EXT: ref_next = 1'b1;
            // RL11 shutdown, codes kept
            CMD_SHDN_BOTH: begin
               sda_next = 1'b1;
               sdb_next = 1'b1;
            end
            CMD_SHDN_A: sda_next = 1'b1;
            CMD_SHDN_B: sdb_next = 1'b1;
            // RL12 power up, codes kept
            CMD_PWR_BOTH: begin
               sda_next = 1'b0;
               sdb_next = 1'b0;
            end
            CMD_PWR_A: sda_next = 1'b0;
            CMD_PWR_B: sdb_next = 1'b0;
            default: begin
               // RL13 first channel range
               if (cmd[5:3] == CMD_RANGE_A_HI && cmd[2:0] <= RANGE_MAX) begin
                  ra_next = cmd[2:0];
               end
               // RL14 second channel range
               if (cmd[5:3] == CMD_RANGE_B_HI && cmd[2:0] <= RANGE_MAX) begin
                  rb_next = cmd[2:0];
               end
            end
         endcase
      end
      // RL16 power-on defaults; codes touched only by load, staging and update commands
      if (!rst_b) begin
         sa_next = CODE_RST;
         sb_next = CODE_RST;
         ca_next = CODE_RST;
         cb_next = CODE_RST;
         ref_next = REF_EXT_RST;
         sda_next = SHDN_RST;
         sdb_next = SHDN_RST;
         ra_next = RANGE_RST;
         rb_next = RANGE_RST;
         stb_next = 1'b0;
         err_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      sa_reg <= sa_next;
      sb_reg <= sb_next;
      ca_reg <= ca_next;
      cb_reg <= cb_next;
      ref_reg <= ref_next;
      sda_reg <= sda_next;
      sdb_reg <= sdb_next;
      ra_reg <= ra_next;
      rb_reg <= rb_next;
      stb_reg <= stb_next;
      err_reg <= err_next;
   end

   assign stage_a = sa_reg;
   assign stage_b = sb_reg;
   assign code_a = ca_reg;
   assign code_b = cb_reg;
   assign ref_external = ref_reg;
   assign shdn_a = sda_reg;
   assign shdn_b = sdb_reg;
   assign range_a = ra_reg;
   assign range_b = rb_reg;
   assign cmd_strobe = stb_reg;
   assign sub_bit_err = err_reg;
endmodule
`default_nettype wire

// ===== dv/ddcd_top_monitor.sv
// Port-level checker for the dual converter command decoder
`timescale 1ns/100ps
`default_nettype none
module ddcd_top_monitor (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst_b,
   // Mode and frame inputs
   input wire logic                 serial_mode,
   input wire logic                 cs_b_pin,
   input wire logic                 tw_bit_valid,
   input wire logic                 tw_start,
   input wire logic [4:0]           tw_pulse_cnt,
   // Channel state
   input wire logic [7:0]           stage_a,
   input wire logic [7:0]           stage_b,
   input wire logic [7:0]           code_a,
   input wire logic [7:0]           code_b,
   input wire logic                 ref_external,
   input wire logic                 shdn_a,
   input wire logic                 shdn_b,
   input wire ddcd_pkg::ddcd_range_t range_a,
   input wire ddcd_pkg::ddcd_range_t range_b,
   input wire logic                 cmd_strobe,
   input wire logic                 sub_bit_err
);
   import ddcd_pkg::*;
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
      else $error("command strobe longer than one cycle");
   a_codes_quiet: assert property (!cmd_strobe |-> $stable({stage_a, stage_b, code_a, code_b}))
      else $error("codes moved without a command");
   a_ctl_quiet: assert property (!cmd_strobe |->
      $stable({ref_external, shdn_a, shdn_b, range_a, range_b, sub_bit_err}))
      else $error("control state moved without a command");
   a_range_legal: assert property (range_a <= RANGE_MAX && range_b <= RANGE_MAX)
      else $error("range outside the six settings");
   a_serial_after_cs: assert property (cmd_strobe && serial_mode |-> cs_b_pin && $past(cs_b_pin, 3))
      else $error("serial command ran before chip select rose");
   // A restart on the same strobe drops the write, so it is left out here
   a_tw_exec: assert property (!serial_mode && tw_bit_valid && !tw_start &&
      tw_pulse_cnt == 5'h1A |=> cmd_strobe)
      else $error("two-wire write not run at pulse 26");
   a_tw_only_last: assert property (!serial_mode && cmd_strobe |->
      $past(tw_bit_valid) && $past(tw_pulse_cnt) == 5'h1A)
      else $error("two-wire command ran off pulse 26");
   a_start_drops: assert property (!serial_mode && tw_start |=> !cmd_strobe)
      else $error("two-wire command ran on a restart");
   a_shdn_keeps_codes: assert property ($rose(shdn_a) || $rose(shdn_b) |->
      $stable({stage_a, stage_b, code_a, code_b}))
      else $error("shutdown altered stored codes");
   a_code_from_stage: assert property (cmd_strobe && code_a != $past(code_a) |-> code_a == stage_a)
      else $error("first output code differs from its staging value");
   a_reset_defaults: assert property (!$past(rst_b) |-> ref_external && !shdn_a && !shdn_b &&
      range_a == RANGE_RST && range_b == RANGE_RST && code_a == CODE_RST)
      else $error("defaults wrong after reset");
   // Main scenarios reached
   c_shutdown: cover property ($rose(shdn_a));
   c_two_wire: cover property (!serial_mode && cmd_strobe);
   c_sub_bits: cover property ($rose(sub_bit_err));
   c_restart: cover property (!serial_mode && tw_start);
endmodule
bind ddcd_top ddcd_top_monitor u_ddcd_top_monitor (.*);
`default_nettype wire

// ===== dv/ddcd_host_model.sv
// Host model driving the serial command pins of the decoder
`timescale 1ns/100ps
`default_nettype none
module ddcd_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      cs_b_pin,
   output logic      sclk_pin,
   output logic      din_pin
);
   // Idle: deselected, clock parked low
   initial begin
      cs_b_pin = 1'b1;
      sclk_pin = 1'b0;
      din_pin = 1'b0;
   end
   // Slow edges (4 clk each) so the pin synchronisers never miss one
   // command first, msb first
   task automatic send(input logic [15:0] f, input int n);
      cs_b_pin <= 1'b0;
      for (int k = 0; k < n; k++) begin
         din_pin <= f[15-k];
         repeat (4) @(posedge clk);
         sclk_pin <= 1'b1;
         repeat (4) @(posedge clk);
         sclk_pin <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_b_pin <= 1'b1;
      din_pin <= ~din_pin; // Released line shows no stale bit
      repeat (12) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== dv/ddcd_top_test.sv
// Self-checking bench for the dual converter command decoder
`timescale 1ns/100ps
`default_nettype none
module ddcd_top_test;
   import ddcd_pkg::*;
   typedef struct packed {
      ddcd_cmd_t   cmd;
      logic [7:0]  data;
      logic [31:0] regs; // Stage a, stage b, code a, code b
      logic [2:0]  ctl;  // Reference, shutdown a, shutdown b
   } ddcd_row_t;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        serial_mode = 1'b1;
   logic        tw_bit_valid = 1'b0;
   logic        tw_bit = 1'b0;
   logic        tw_start = 1'b0;
   logic [4:0]  tw_pulse_cnt = 5'h00;
   wire logic   cs_b_pin, sclk_pin, din_pin;
   logic [7:0]  stage_a, stage_b, code_a, code_b;
   logic        ref_external, shdn_a, shdn_b, cmd_strobe, sub_bit_err;
   ddcd_range_t range_a, range_b;
   wire logic [40:0] state_v = {stage_a, stage_b, code_a, code_b, ref_external, shdn_a,
                                shdn_b, range_a, range_b};
   int          errors = 0;
   int          compares = 0;
   int          strobes = 0;
   // Command rows with the state each should leave
   ddcd_row_t rows [21] = '{
      '{6'h01, 8'hA5, 32'hA5A5_A5A5, 3'h4}, '{6'h02, 8'h3C, 32'h3CA5_3CA5, 3'h4},
      '{6'h03, 8'hC3, 32'h3CC3_3CC3, 3'h4}, '{6'h04, 8'h11, 32'h1111_3CC3, 3'h4},
      '{6'h05, 8'h22, 32'h2211_3CC3, 3'h4}, '{6'h06, 8'h33, 32'h2233_3CC3, 3'h4},
      '{6'h09, 8'hFF, 32'h2233_22C3, 3'h4}, '{6'h0A, 8'hFF, 32'h2233_2233, 3'h4},
      '{6'h05, 8'h44, 32'h4433_2233, 3'h4}, '{6'h06, 8'h55, 32'h4455_2233, 3'h4},
      '{6'h07, 8'hFF, 32'h4455_4455, 3'h4}, '{6'h0B, 8'hFF, 32'h4455_4455, 3'h0},
      '{6'h0E, 8'hFF, 32'h4455_4455, 3'h2}, '{6'h0F, 8'hFF, 32'h4455_4455, 3'h3},
      '{6'h2E, 8'h00, 32'h4455_4455, 3'h1}, '{6'h0D, 8'h00, 32'h4455_4455, 3'h3},
      '{6'h02, 8'h66, 32'h6655_6655, 3'h3}, '{6'h2D, 8'hFF, 32'h6655_6655, 3'h0},
      '{6'h0C, 8'hFF, 32'h6655_6655, 3'h4}, '{6'h00, 8'h77, 32'h6655_6655, 3'h4},
      '{6'h08, 8'h77, 32'h6655_6655, 3'h4}};
   ddcd_top u_ddcd_top (.*);
   ddcd_host_model u_ddcd_host_model (.*);
   // 250 MHz clock
   always #2 clk = ~clk;
   // Count executed frames; a strobe that sticks or repeats shows up here
   always @(posedge clk) begin
      if (cmd_strobe === 1'b1) begin
         strobes++;
      end
   end
   task automatic check(input string what, input logic [40:0] exp, input logic [40:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Two-wire bits with the pulse numbers that end at last
   task automatic tw_send(input logic [15:0] f, input logic [4:0] last);
      for (int k = 0; k < 16; k++) begin
         tw_bit_valid <= 1'b1;
         tw_bit <= f[15-k];
         tw_pulse_cnt <= last - 5'h0F + 5'(k);
         @(posedge clk);
      end
      tw_bit_valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, well past the few thousand cycles of the run
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      check("reset state", {32'h0, 3'h4, 6'h00}, state_v);
      foreach (rows[i]) begin
         u_ddcd_host_model.send({rows[i].cmd, rows[i].data, 2'b00}, 16);
         check("row state", {rows[i].regs, rows[i].ctl, 6'h00}, state_v);
      end
      for (int i = 0; i < 6; i++) begin
         u_ddcd_host_model.send({CMD_RANGE_A_HI, 3'(i), 8'hFF, 2'b00}, 16);
         check("range a", {32'h6655_6655, 3'h4, 3'(i), 3'h0}, state_v);
      end
      for (int i = 0; i < 6; i++) begin
         u_ddcd_host_model.send({CMD_RANGE_B_HI, 3'(i), 8'hFF, 2'b00}, 16);
         check("range b", {32'h6655_6655, 3'h4, 3'h5, 3'(i)}, state_v);
      end
      // Unassigned range code, then a frame cut short
      u_ddcd_host_model.send({6'h16, 8'hFF, 2'b00}, 16);
      check("unassigned", {32'h6655_6655, 3'h4, 6'h2D}, state_v);
      u_ddcd_host_model.send({CMD_LOAD_BOTH, 8'h99, 2'b00}, 12);
      check("short frame", {32'h6655_6655, 3'h4, 6'h2D}, state_v);
      u_ddcd_host_model.send({CMD_LOAD_A, 8'h77, 2'b11}, 16);
      check("sub bits", {32'h7755_7755, 3'h4, 6'h2D}, state_v);
      check("sub flag", 41'(1), 41'(sub_bit_err));
      // Two-wire: aborted write, then a full one
      serial_mode <= 1'b0;
      @(posedge clk);
      tw_send({CMD_LOAD_B, 8'hE7, 2'b00}, 5'h19);
      check("tw abort", {32'h7755_7755, 3'h4, 6'h2D}, state_v);
      // A restart between writes must not disturb the next one
      tw_start <= 1'b1;
      @(posedge clk);
      tw_start <= 1'b0;
      tw_send({CMD_LOAD_B, 8'hE7, 2'b00}, 5'h1A);
      check("tw write", {32'h77E7_77E7, 3'h4, 6'h2D}, state_v);
      check("tw flag", 41'(0), 41'(sub_bit_err));
      // Every full frame ran once; short, aborted and restart ran none
      check("strobe count", 41'(36), 41'(strobes));
      // Second reset from a non-default state brings back the defaults
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      check("reset again", {32'h0, 3'h4, 6'h00}, state_v);
      tally_and_finish();
   end
endmodule
`default_nettype wire
